// ---- pkg/timer_mode_consts.vh ----
// Purpose: Offsets, field positions, reset values and timing for the timer
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Included by the timer design file only
`ifndef TIMER_MODE_CONSTS_VH
`define TIMER_MODE_CONSTS_VH

`define OFS_CONTROL     8'h00
`define OFS_COUNT       8'h04
`define OFS_PERIOD      8'h08
`define OFS_STATUS      8'h0C

`define BIT_TIMER_ON    15
`define BIT_STOP_IDLE   13
`define BIT_GATE_EN     6
`define BIT_PRESC_HI    5
`define BIT_PRESC_LO    4
`define BIT_SYNC_SEL    2
`define BIT_CLK_SRC     1
`define BIT_IRQ_FLAG    0

`define CONTROL_RESET   16'h0000
`define CONTROL_MASK_A  16'hA076
`define CONTROL_MASK_BC 16'hA072
`define COUNT_RESET     16'h0000
`define PERIOD_RESET    16'hFFFF

`define PRESC_1         2'h0
`define PRESC_8         2'h1
`define PRESC_64        2'h2
`define PRESC_256       2'h3
`define DIV_1           8'h00
`define DIV_8           8'h07
`define DIV_64          8'h3F
`define DIV_256         8'hFF

`define OSC_PER_INSTR   2'h3
`define SAMPLE_A_PHASE  2'h0
`define SAMPLE_B_PHASE  2'h2

`define TYPE_A          2'h0
`define TYPE_B          2'h1
`define TYPE_C          2'h2

`endif

// ---- hdl/timer_mode_clock_select.v ----
// Purpose: 16-bit time base with mode and clock path select, APB slave
// Assumes: mclk is the oscillator; instruction cycle is four mclk periods
// Notes:   Behaviour
// Behaviour
// - Four modes: timer, synced counter, gated timer, async counter (type A).
// - Clock source bit 1 clear feeds timer from instruction clock, Fosc/4.
// - Type A has sync select at bit 2; other variants lack it.
// - Gate control bit 6 selects gated timer mode.
// - Bit 15 enables the timer when set, halts it when clear.
// - Internal timer at 1:1 prescale advances once per instruction cycle.
// - Sync select has no effect while internal clock is chosen.
// - With clock source set, count on each rising edge of the pin.
// - Type B and C always synchronize the external clock.
// - Synchronizer samples the pin twice per instruction cycle.
// - Synchronized external counting stops during sleep.
// - Type A unsynchronized counts directly on external edges.
// - Async type A counts in sleep and can raise a wake flag.
// - Async type A accepts a slow 32 kHz crystal as its clock.
// - Period match sets the flag; only software clears it.
// - Writing zero to control stops timer and clears the prescaler; count and period hold.
// - Control word 0x8016 starts synced counting at 1:8 prescale.
// - Stop-in-idle bit halts timer in idle; clear keeps it running.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "timer_mode_consts.vh"

module timer_mode_clock_select #(
  parameter [1:0] TIMER_TYPE = `TYPE_A
) (
  input  wire        mclk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        extCountClockPin,
  input  wire        gatePin,
  input  wire        sleepMode,
  input  wire        idleMode,
  output wire        firstTimerIrqFlag,
  output wire        instrCycleClock
);

  localparam [15:0] CTRL_MASK = (TIMER_TYPE == `TYPE_A) ?
                                `CONTROL_MASK_A : `CONTROL_MASK_BC;

  reg  [15:0] controlReg_ff;
  reg  [15:0] count_ff;
  reg  [15:0] period_ff;
  reg         irqFlag_ff;
  reg  [1:0]  phase_ff;
  reg  [7:0]  prescCnt_ff;
  reg         extMeta_ff;
  reg         extSync_ff;
  reg         extPrev_ff;
  reg         sampleA_ff;
  reg         sampleB_ff;
  reg         gateMeta_ff;
  reg         gateSync_ff;
  reg         sleepMeta_ff;
  reg         sleepSync_ff;
  reg         idleMeta_ff;
  reg         idleSync_ff;

  reg  [15:0] nxt_count;
  reg  [7:0]  nxt_prescCnt;
  reg         nxt_irqFlag;
  reg  [31:0] nxt_prdata;
  reg  [7:0]  divLimit;
  reg         sourceEvent;

  wire        timerOn;
  wire        stopIdle;
  wire        gateEn;
  wire        clkSrc;
  wire        syncSel;
  wire [1:0]  prescSel;
  wire        useSync;
  wire        instrTick;
  wire        syncEdge;
  wire        asyncEdge;
  wire        running;
  wire        countEvent;
  wire        prescDone;
  wire        periodMatch;
  wire        setup;
  wire        access;
  wire        wrAccess;
  wire        mapped;

  assign timerOn  = controlReg_ff[`BIT_TIMER_ON];
  assign stopIdle = controlReg_ff[`BIT_STOP_IDLE];
  assign clkSrc   = controlReg_ff[`BIT_CLK_SRC];
  assign prescSel = controlReg_ff[`BIT_PRESC_HI:`BIT_PRESC_LO];
  assign gateEn   = controlReg_ff[`BIT_GATE_EN] & ~clkSrc;
  assign syncSel  = controlReg_ff[`BIT_SYNC_SEL];

  // Only type A may bypass the synchronizer
  assign useSync = (TIMER_TYPE != `TYPE_A) | syncSel;

  // Instruction clock: one tick in four oscillator periods
  assign instrTick       = (phase_ff == `OSC_PER_INSTR);
  assign instrCycleClock = instrTick;

  // Pin sampled at two phases of each instruction cycle; edge when
  // either later sample sees high after the earlier saw low
  assign syncEdge = ((phase_ff == `SAMPLE_A_PHASE) & ~sampleB_ff &
                     extSync_ff) |
                    ((phase_ff == `SAMPLE_B_PHASE) & ~sampleA_ff &
                     extSync_ff);

  // Unsynchronized path: one clock has to stand in for the crystal domain,
  // so only the pin's two-flop resync lies in the path
  assign asyncEdge = extSync_ff & ~extPrev_ff;

  always @* begin
    sourceEvent = 1'b0;
    if (!clkSrc) begin
      // Sync select ignored for the internal path
      if (gateEn)
        sourceEvent = instrTick & gateSync_ff & ~sleepSync_ff;
      else
        sourceEvent = instrTick & ~sleepSync_ff;
    end else if (useSync) begin
      sourceEvent = syncEdge & ~sleepSync_ff;
    end else begin
      sourceEvent = asyncEdge;
    end
  end

  assign running    = timerOn & ~(idleSync_ff & stopIdle);
  assign countEvent = running & sourceEvent;

  always @* begin
    case (prescSel)
      `PRESC_1:   divLimit = `DIV_1;
      `PRESC_8:   divLimit = `DIV_8;
      `PRESC_64:  divLimit = `DIV_64;
      `PRESC_256: divLimit = `DIV_256;
      default:    divLimit = `DIV_1;
    endcase
  end

  assign prescDone   = countEvent & (prescCnt_ff >= divLimit);
  assign periodMatch = prescDone & (count_ff == period_ff);

  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign wrAccess = access & pwrite;
  assign pready   = 1'b1;
  assign mapped   = (paddr == `OFS_CONTROL) | (paddr == `OFS_COUNT) |
                    (paddr == `OFS_PERIOD)  | (paddr == `OFS_STATUS);
  assign pslverr  = access & ~mapped;
  assign firstTimerIrqFlag = irqFlag_ff;

  always @* begin
    nxt_prescCnt = prescCnt_ff;
    if (countEvent) begin
      if (prescDone)
        nxt_prescCnt = 8'h00;
      else
        nxt_prescCnt = prescCnt_ff + 8'h01;
    end
    if (!timerOn)
      nxt_prescCnt = 8'h00;
  end

  always @* begin
    nxt_count = count_ff;
    if (periodMatch)
      nxt_count = `COUNT_RESET;
    else if (prescDone)
      nxt_count = count_ff + 16'h0001;
    if (wrAccess && paddr == `OFS_COUNT)
      nxt_count = pwdata[15:0];
  end

  // Set beats a same-cycle software clear
  always @* begin
    nxt_irqFlag = irqFlag_ff;
    if (wrAccess && paddr == `OFS_STATUS && pwdata[`BIT_IRQ_FLAG])
      nxt_irqFlag = 1'b0;
    if (periodMatch)
      nxt_irqFlag = 1'b1;
  end

  // Reads of a count running off the pin may catch it mid-change
  always @* begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_CONTROL: nxt_prdata = {16'h0000,
                                  controlReg_ff & ~(16'h0040 &
                                  {16{clkSrc}})};
      `OFS_COUNT:   nxt_prdata = {16'h0000, count_ff};
      `OFS_PERIOD:  nxt_prdata = {16'h0000, period_ff};
      `OFS_STATUS:  nxt_prdata = {31'h0000_0000, irqFlag_ff};
      default:      nxt_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      controlReg_ff <= `CONTROL_RESET;
      count_ff      <= `COUNT_RESET;
      period_ff     <= `PERIOD_RESET;
      irqFlag_ff    <= 1'b0;
      phase_ff      <= 2'h0;
      prescCnt_ff   <= 8'h00;
      prdata        <= 32'h0000_0000;
    end else begin
      phase_ff    <= phase_ff + 2'h1;
      prescCnt_ff <= nxt_prescCnt;
      count_ff    <= nxt_count;
      irqFlag_ff  <= nxt_irqFlag;
      if (setup)
        prdata <= nxt_prdata;
      if (wrAccess && paddr == `OFS_CONTROL)
        controlReg_ff <= pwdata[15:0] & CTRL_MASK;
      if (wrAccess && paddr == `OFS_PERIOD)
        period_ff <= pwdata[15:0];
    end
  end

  // Pin and mode inputs: two flops before any logic
  always @(posedge mclk) begin
    if (reset) begin
      extMeta_ff   <= 1'b0;
      extSync_ff   <= 1'b0;
      extPrev_ff   <= 1'b0;
      sampleA_ff   <= 1'b0;
      sampleB_ff   <= 1'b0;
      gateMeta_ff  <= 1'b0;
      gateSync_ff  <= 1'b0;
      sleepMeta_ff <= 1'b0;
      sleepSync_ff <= 1'b0;
      idleMeta_ff  <= 1'b0;
      idleSync_ff  <= 1'b0;
    end else begin
      extMeta_ff   <= extCountClockPin;
      extSync_ff   <= extMeta_ff;
      extPrev_ff   <= extSync_ff;
      gateMeta_ff  <= gatePin;
      gateSync_ff  <= gateMeta_ff;
      sleepMeta_ff <= sleepMode;
      sleepSync_ff <= sleepMeta_ff;
      idleMeta_ff  <= idleMode;
      idleSync_ff  <= idleMeta_ff;
      if (phase_ff == `SAMPLE_A_PHASE)
        sampleA_ff <= extSync_ff;
      if (phase_ff == `SAMPLE_B_PHASE)
        sampleB_ff <= extSync_ff;
    end
  end

endmodule
`default_nettype wire

// ---- verification/timer_mode_checker_sva.sv ----
// Purpose: Port-level checks for the timer mode and clock select block
// Assumes: Zero-wait APB slave, register data in bits 15:0
// Notes:   Bound from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module timer_mode_checker #(
  parameter logic [1:0] TIMER_TYPE = 2'h0
) (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        extCountClockPin,
  input wire logic        gatePin,
  input wire logic        sleepMode,
  input wire logic        idleMode,
  input wire logic        firstTimerIrqFlag,
  input wire logic        instrCycleClock
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic acc = psel && penable;
  wire logic rdAcc = acc && !pwrite;
  wire logic clr = acc && pwrite && paddr == 8'h0C && pwdata[0];
  wire logic mapped = paddr[1:0] == 2'h0 && paddr[7:4] == 4'h0;
  wire logic [15:0] ctlMask = TIMER_TYPE == 2'h0 ? 16'hA076 : 16'hA072;
  sequence s_gap;
    !instrCycleClock [*3] ##1 instrCycleClock;
  endsequence
  property p_tick;
    instrCycleClock |=> s_gap;
  endproperty
  a_tick: assert property (p_tick)
    else $error("instruction tick spacing wrong");
  property p_sticky;
    firstTimerIrqFlag && !clr |=> firstTimerIrqFlag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clear");
  property p_stat;
    rdAcc && paddr == 8'h0C |-> prdata == {31'h0, $past(firstTimerIrqFlag)};
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read differs from flag");
  property p_mask;
    rdAcc && paddr == 8'h00 |-> (prdata[15:0] & ~ctlMask) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask)
    else $error("unimplemented control bit reads one");
  property p_gate;
    rdAcc && paddr == 8'h00 && prdata[1] |-> !prdata[6];
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate bit visible with external clock");
  property p_upper;
    rdAcc |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits not zero");
  property p_err;
    acc |-> pready && pslverr == !mapped;
  endproperty
  a_err: assert property (p_err)
    else $error("wrong ready or error response");
  property p_unmap;
    rdAcc && !mapped |-> prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- verification/ext_clock_source.sv ----
// Purpose: Model of the external clock source on the count pin
// Assumes: Pulse widths given in mclk cycles
// Notes:   Pin rests low between bursts so a stalled count shows
`timescale 1ns/1ns
`default_nettype none
module ext_clock_source (
  input  wire logic mclk,
  output var  logic extCountClockPin
);
  initial extCountClockPin = 1'h0;
  // Widths of at least two instruction cycles suit synced mode
  task automatic pulses(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      extCountClockPin <= 1'h1;
      repeat (half) @(posedge mclk);
      extCountClockPin <= 1'h0;
      repeat (half) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_timer_mode_clock_select.sv ----
// Purpose: Self-checking bench for the timer mode and clock select block
// Assumes: APB answers in the access cycle; count measured by reads
// Notes:   Rates use two reads exactly 40 mclk apart
`timescale 1ns/1ns
`default_nettype none
module tb_timer_mode_clock_select;
  localparam logic [1:0] TIMER_TYPE = 2'h0;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        gatePin = 1'h0;
  logic        sleepMode = 1'h0;
  logic        idleMode = 1'h0;
  logic [31:0] a;
  logic [31:0] b;
  wire         pready;
  wire         pslverr;
  wire         pin;
  wire         irqFlag;
  wire         tick;
  wire  [31:0] prdata;
  int          failures = 0;
  int          n_tests = 0;
  always #50 mclk = ~mclk;
  timer_mode_clock_select #(.TIMER_TYPE(TIMER_TYPE)) i_timer_mode_clock_select (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .extCountClockPin(pin),
    .gatePin(gatePin), .sleepMode(sleepMode), .idleMode(idleMode),
    .firstTimerIrqFlag(irqFlag), .instrCycleClock(tick));
  ext_clock_source i_ext_clock_source (.mclk(mclk), .extCountClockPin(pin));
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // One idle cycle after each transfer keeps drivers single per step
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] d, output logic [31:0] q);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e, string nm);
    xfer(1'h0, ad, 32'h0, a);
    check(nm, a, e);
  endtask
  task automatic rate(input logic [31:0] ctl, e, input string nm);
    xfer(1'h1, 8'h00, ctl, a);
    xfer(1'h0, 8'h04, 32'h0, a);
    repeat (37) @(posedge mclk);
    xfer(1'h0, 8'h04, 32'h0, b);
    check(nm, b - a, e);
  endtask
  task automatic pins(input logic [31:0] ctl, input int n, h,
                      input logic [31:0] e, input string nm);
    xfer(1'h1, 8'h00, 32'h0, a);
    xfer(1'h1, 8'h00, ctl, a);
    xfer(1'h0, 8'h04, 32'h0, a);
    i_ext_clock_source.pulses(n, h);
    repeat (8) @(posedge mclk);
    xfer(1'h0, 8'h04, 32'h0, b); // read after pin stops
    check(nm, b - a, e);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    rdc(8'h00, 32'h0, "control");
    rdc(8'h08, 32'hFFFF, "period");
    rdc(8'h10, 32'h0, "unmapped");
    rate(32'h8000, 32'hA, "timer");
    rate(32'h8004, 32'hA, "timer sync");
    rate(32'h0004, 32'h0, "halted");
    rate(32'h8040, 32'h0, "gate low");
    gatePin <= 1'h1;
    rate(32'h8040, 32'hA, "gate high");
    idleMode <= 1'h1;
    rate(32'hA000, 32'h0, "idle stop");
    rate(32'h8000, 32'hA, "idle run");
    idleMode <= 1'h0;
    pins(32'h8016, 16, 12, 32'h2, "sync div8");
    sleepMode <= 1'h1;
    pins(32'h8006, 3, 12, 32'h0, "sync sleep");
    pins(32'h8002, 5, 3, 32'h5, "async sleep");
    sleepMode <= 1'h0;
    pins(32'h8006, 3, 12, 32'h3, "sync");
    pins(32'h8042, 2, 156, 32'h2, "slow async");
    rdc(8'h00, 32'h8002, "gate hidden");
    xfer(1'h1, 8'h08, 32'h3, a);
    xfer(1'h1, 8'h04, 32'h0, a);
    xfer(1'h1, 8'h00, 32'h8000, a);
    repeat (20) @(posedge mclk);
    xfer(1'h1, 8'h00, 32'h0, a);
    xfer(1'h0, 8'h04, 32'h0, a);
    check("wrap", {31'h0, a < 32'h4}, 32'h1);
    rdc(8'h0C, 32'h1, "flag");
    rdc(8'h0C, 32'h1, "flag held");
    xfer(1'h1, 8'h0C, 32'h1, a);
    rdc(8'h0C, 32'h0, "flag cleared");
    report_and_stop;
  end
endmodule
bind timer_mode_clock_select timer_mode_checker #(.TIMER_TYPE(TIMER_TYPE))
  i_timer_mode_checker (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .extCountClockPin(extCountClockPin), .gatePin(gatePin),
  .sleepMode(sleepMode), .idleMode(idleMode),
  .firstTimerIrqFlag(firstTimerIrqFlag), .instrCycleClock(instrCycleClock));
`default_nettype wire
